//--- design/ilcd_decoder.sv
// module: opcode length, cycle count and control-flow decoder
`timescale 1ns/1ps
`default_nettype none
module ilcd_decoder
#(
   parameter logic [15:0] ONCHIP_EXTENDED_RAM_SIZE = 16'h1000
)
(
   input  wire logic               ref_clk,
   input  wire logic               sys_rst,
   input  wire logic               in_valid,
   output logic                    in_ready,
   input  wire ilcd_pkg::ilcd_req_t in_req,
   output logic                    out_valid,
   output ilcd_pkg::ilcd_res_t     out_res
);
   import ilcd_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // opcode table

   function automatic ilcd_dec_t mk(input logic [1:0] l, input logic [3:0] c,
                                    input logic cd, input ilcd_kind_t k);
      ilcd_dec_t d;
      d.len  = l;
      d.cyc  = c;
      d.cond = cd;
      d.kind = k;
      return d;
   endfunction

   // first match wins: rows that break the column pattern come first
   function automatic ilcd_dec_t decode(input logic [7:0] op);
      ilcd_dec_t d;
      d = mk(LEN_ONE, CYC_ONE, 1'b0, K_PLAIN);
      casez (op)
         8'h00: d = mk(LEN_ONE, CYC_ONE, 1'b0, K_PLAIN);
         8'h10: d = mk(LEN_THREE, CYC_THREE, 1'b1, K_JBC);      // RL18
         8'h20,
         8'h30: d = mk(LEN_THREE, CYC_THREE, 1'b1, K_REL3);     // RL18
         8'h40,
         8'h50: d = mk(LEN_TWO, CYC_TWO, 1'b1, K_REL2);         // RL17
         8'h60,
         8'h70: d = mk(LEN_TWO, CYC_TWO, 1'b1, K_REL2);         // RL21
         8'h80: d = mk(LEN_TWO, CYC_THREE, 1'b0, K_REL2);       // RL19
         8'h90: d = mk(LEN_THREE, CYC_THREE, 1'b0, K_PLAIN);    // RL9
         8'hA0,
         8'hB0: d = mk(LEN_TWO, CYC_TWO, 1'b0, K_PLAIN);        // RL16
         8'hC0,
         8'hD0: d = mk(LEN_TWO, CYC_TWO, 1'b0, K_PLAIN);        // RL13
         8'hE0,
         8'hF0: d = mk(LEN_ONE, CYC_THREE, 1'b0, K_XD_DP);      // RL11
         8'b???0_0001,
         8'b???1_0001: d = mk(LEN_TWO, CYC_THREE, 1'b0, K_ABS11); // RL25
         8'h02,
         8'h12: d = mk(LEN_THREE, CYC_FOUR, 1'b0, K_ABS16);     // RL25
         8'h22,
         8'h32: d = mk(LEN_ONE, CYC_FIVE, 1'b0, K_RET);         // RL25
         8'h42,
         8'h52,
         8'h62: d = mk(LEN_TWO, CYC_TWO, 1'b0, K_PLAIN);        // RL6
         8'h72,
         8'h82,
         8'h92,
         8'hA2,
         8'hB2,
         8'hC2,
         8'hD2: d = mk(LEN_TWO, CYC_TWO, 1'b0, K_PLAIN);        // RL16
         8'hE2,
         8'hE3,
         8'hF2,
         8'hF3: d = mk(LEN_ONE, CYC_THREE, 1'b0, K_XD_IDX);     // RL11
         8'h03,
         8'h13,
         8'h23,
         8'h33: d = mk(LEN_ONE, CYC_ONE, 1'b0, K_PLAIN);        // RL7
         8'h43,
         8'h53,
         8'h63: d = mk(LEN_THREE, CYC_THREE, 1'b0, K_PLAIN);    // RL5
         8'h73: d = mk(LEN_ONE, CYC_THREE, 1'b0, K_INDJMP);     // RL20
         8'h83,
         8'h93: d = mk(LEN_ONE, CYC_THREE, 1'b0, K_CODERD);     // RL10
         8'hA3: d = mk(LEN_ONE, CYC_ONE, 1'b0, K_PLAIN);        // RL26
         8'hB3,
         8'hC3,
         8'hD3: d = mk(LEN_ONE, CYC_ONE, 1'b0, K_PLAIN);
         8'h04,
         8'h14: d = mk(LEN_ONE, CYC_ONE, 1'b0, K_PLAIN);        // RL26
         8'h84: d = mk(LEN_ONE, CYC_EIGHT, 1'b0, K_PLAIN);      // RL24
         8'hA4: d = mk(LEN_ONE, CYC_FOUR, 1'b0, K_PLAIN);       // RL24
         8'hB4: d = mk(LEN_THREE, CYC_THREE, 1'b1, K_REL3);
         8'hC4,
         8'hD4,
         8'hE4,
         8'hF4: d = mk(LEN_ONE, CYC_ONE, 1'b0, K_PLAIN);        // RL7
         8'b????0100: d = mk(LEN_TWO, CYC_TWO, 1'b0, K_PLAIN); // RL3
         // column 5..F special rows
         8'h75,
         8'h85: d = mk(LEN_THREE, CYC_THREE, 1'b0, K_PLAIN);    // RL8
         8'h76,
         8'h77: d = mk(LEN_TWO, CYC_TWO, 1'b0, K_PLAIN);        // RL12
         8'b0111_1???,
         8'b1000_011?,
         8'b1000_1???: d = mk(LEN_TWO, CYC_TWO, 1'b0, K_PLAIN);
         8'hA5: d = mk(LEN_ONE, CYC_ONE, 1'b0, K_PLAIN);        // spare nop
         8'hA6,
         8'hA7: d = mk(LEN_TWO, CYC_TWO, 1'b0, K_PLAIN);        // RL12
         8'b1010_1???: d = mk(LEN_TWO, CYC_TWO, 1'b0, K_PLAIN);
         8'hB5,
         8'b1011_1???: d = mk(LEN_THREE, CYC_THREE, 1'b1, K_REL3);
         8'hB6,
         8'hB7: d = mk(LEN_THREE, CYC_FOUR, 1'b1, K_REL3);
         8'hD5: d = mk(LEN_THREE, CYC_THREE, 1'b1, K_REL3);
         8'hD6,
         8'hD7: d = mk(LEN_ONE, CYC_TWO, 1'b0, K_NIBX);         // RL15
         8'b1101_1???: d = mk(LEN_TWO, CYC_TWO, 1'b1, K_REL2);
         8'hC5: d = mk(LEN_TWO, CYC_TWO, 1'b0, K_PLAIN);        // RL14
         8'hC8,
         8'hC9,
         8'hCA,
         8'hCB,
         8'hCC,
         8'hCD,
         8'hCE,
         8'hCF: d = mk(LEN_ONE, CYC_ONE, 1'b0, K_PLAIN);        // RL14
         // generic columns: direct, indirect, register forms
         8'b????0101: d = mk(LEN_TWO, CYC_TWO, 1'b0, K_PLAIN); // RL3
         8'b????011?: d = mk(LEN_ONE, CYC_TWO, 1'b0, K_PLAIN); // RL4
         8'b????_1???: d = mk(LEN_ONE, CYC_ONE, 1'b0, K_PLAIN); // RL2
         default: d = mk(LEN_ONE, CYC_ONE, 1'b0, K_PLAIN);
      endcase
      return d;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // combinational classification of the presented instruction

   ilcd_dec_t   dec;
   ilcd_res_t   res_new;
   logic [15:0] next_pc;
   logic [15:0] rel_sext;
   logic        is_taken;

   // targets are computed for jump and code-read opcodes but only flagged valid for jumps
   always_comb
   begin
      dec      = decode(in_req.opcode);
      next_pc  = in_req.pc + {14'h0000, dec.len};
      rel_sext = (dec.kind == K_REL3) || (dec.kind == K_JBC)
               ? {{8{in_req.byte2[7]}}, in_req.byte2}
               : {{8{in_req.byte1[7]}}, in_req.byte1};      // RL23
      is_taken = dec.cond & in_req.cond_true;
      res_new           = '0;
      res_new.len       = dec.len;
      res_new.next_pc   = next_pc;
      res_new.taken     = is_taken;
      res_new.cycles    = is_taken ? dec.cyc + CYC_TAKEN : dec.cyc; // RL22
      res_new.xtarget   = XT_NONE;
      res_new.xaddr     = '0;
      unique case (dec.kind)
         K_REL2,
         K_REL3:
         begin
            res_new.target_ok = is_taken | ~dec.cond;           // RL19
            res_new.target    = next_pc + rel_sext;             // RL23
         end
         K_JBC:
         begin
            res_new.target_ok = is_taken;
            res_new.target    = next_pc + rel_sext;             // RL23
            res_new.clear_bit = in_req.bit_set;                 // RL18
         end
         K_ABS11:
         begin
            res_new.target_ok = 1'b1;
            res_new.target    = {next_pc[15:11], in_req.opcode[7:5],
                                 in_req.byte1};                 // RL25
         end
         K_ABS16:
         begin
            res_new.target_ok = 1'b1;
            res_new.target    = {in_req.byte1, in_req.byte2};   // RL25
         end
         K_INDJMP:
         begin
            res_new.target_ok = 1'b1;
            res_new.target    = in_req.data_pointer_16
                              + {8'h00, in_req.acc};            // RL20
         end
         K_CODERD:
         begin
            // code address rides on the target field, not a jump
            res_new.target    = (in_req.opcode[4] ? in_req.data_pointer_16 : next_pc)
                              + {8'h00, in_req.acc};            // RL10
         end
         K_XD_IDX,
         K_XD_DP:
         begin
            res_new.xaddr = (dec.kind == K_XD_DP) ? in_req.data_pointer_16
                          : {in_req.xpage, in_req.idx_reg};     // RL11
            if (in_req.flash_sel)
               res_new.xtarget = XT_FLASH;                      // RL1
            else if (res_new.xaddr < ONCHIP_EXTENDED_RAM_SIZE)
               res_new.xtarget = XT_ONCHIP;                     // RL1
            else
               res_new.xtarget = XT_OFFCHIP;                    // RL1
         end
         K_NIBX:
         begin
            res_new.nib_ok  = 1'b1;
            res_new.nib_acc = {in_req.acc[7:4], in_req.ram_byte[3:0]};
            res_new.nib_ram = {in_req.ram_byte[7:4], in_req.acc[3:0]}; // RL15
         end
         K_RET,
         K_PLAIN:
         begin
            // return address comes from the stack, outside this block
            res_new.target_ok = 1'b0;
         end
         default:
         begin
            res_new.target_ok = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // execution timer: holds the result for the instruction's cycle count

   ilcd_state_t state_reg;
   ilcd_state_t state_next;
   logic [3:0]  cnt_reg;
   logic [3:0]  cnt_next;
   ilcd_res_t   res_reg;
   ilcd_res_t   res_next;

   // one new instruction only after the previous one has run its cycles
   always_comb
   begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      res_next   = res_reg;
      unique case (state_reg)
         ST_IDLE:
         begin
            if (in_valid)
            begin
               state_next = ST_BUSY;
               cnt_next   = res_new.cycles;                     // RL22
               res_next   = res_new;
            end
         end
         ST_BUSY:
         begin
            cnt_next = cnt_reg - 4'h1;
            if (cnt_reg == CYC_ONE)
               state_next = ST_IDLE;
         end
      endcase
   end

   // registers only
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state_reg <= ST_IDLE;
         cnt_reg   <= CNT_RST;
         res_reg   <= '0;
      end
      else
      begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         res_reg   <= res_next;
      end
   end

   // handshake outputs are combinational, data from flip-flops
   assign in_ready  = (state_reg == ST_IDLE);
   assign out_valid = (state_reg == ST_BUSY) && (cnt_reg == CYC_ONE);
   assign out_res   = res_reg;

endmodule // ilcd_decoder
`default_nettype wire

//--- design/ilcd_pkg.sv
// package: constants and carriers for the instruction length/cycle decoder
// Operation
// RL1 - external_data_move routes to three memory targets
// RL2 - bank_register arithmetic: one byte, one cycle
// RL3 - direct/immediate arithmetic: two bytes, two cycles
// RL4 - indirect arithmetic: one byte, two cycles
// RL5 - logic immediate into direct: three bytes, cycles
// RL6 - logic accumulator into direct: two bytes, cycles
// RL7 - accumulator-only operations: one byte, one cycle
// RL8 - direct to direct move: three bytes, cycles
// RL9 - data_pointer_16 load: three bytes, three cycles
// RL10 - code_byte_read: one byte, three cycles
// RL11 - external_data_move: one byte, three cycles
// RL12 - moves into indirect RAM take two cycles
// RL13 - push and pop: two bytes, two cycles
// RL14 - exchange: register one cycle, direct two
// RL15 - low_nibble_exchange swaps bits 3..0, two cycles
// RL16 - direct bit operations: two bytes, two cycles
// RL17 - carry jumps: two bytes, two or three
// RL18 - bit jumps: three bytes, clear on set
// RL19 - short_relative_jump: two bytes, three cycles
// RL20 - indirect jump: one byte, three cycles
// RL21 - zero jumps: two bytes, two or three
// RL22 - taken branch uses the larger count
// RL23 - relative offset signed, from next instruction
// RL24 - multiply four cycles, divide eight cycles
// RL25 - calls, long jumps, returns fixed timing
// RL26 - increment/decrement cycle counts by form
package ilcd_pkg;
   // instruction lengths in bytes
   localparam logic [1:0] LEN_ONE    = 2'h1;
   localparam logic [1:0] LEN_TWO    = 2'h2;
   localparam logic [1:0] LEN_THREE  = 2'h3;
   // execution counts in clock cycles (not-taken count for branches)
   localparam logic [3:0] CYC_ONE    = 4'h1;
   localparam logic [3:0] CYC_TWO    = 4'h2;
   localparam logic [3:0] CYC_THREE  = 4'h3;
   localparam logic [3:0] CYC_FOUR   = 4'h4;
   localparam logic [3:0] CYC_FIVE   = 4'h5;
   localparam logic [3:0] CYC_EIGHT  = 4'h8;
   localparam logic [3:0] CYC_TAKEN  = 4'h1;    // extra cycle when taken
   // reset values
   localparam logic [3:0] CNT_RST    = 4'h0;

   // control-flow / side-effect class of an opcode
   typedef enum logic [3:0] {
      K_PLAIN    = 4'h0,
      K_REL2     = 4'h1,   // rel in second byte
      K_REL3     = 4'h2,   // rel in third byte
      K_ABS11    = 4'h3,
      K_ABS16    = 4'h4,
      K_INDJMP   = 4'h5,
      K_RET      = 4'h6,
      K_XD_IDX   = 4'h7,   // external move, 8-bit index address
      K_XD_DP    = 4'h8,   // external move, 16-bit pointer address
      K_JBC      = 4'h9,
      K_NIBX     = 4'hA,
      K_CODERD   = 4'hB
   } ilcd_kind_t;

   typedef enum logic [1:0] {
      XT_NONE    = 2'h0,
      XT_ONCHIP  = 2'h1,
      XT_OFFCHIP = 2'h2,
      XT_FLASH   = 2'h3
   } ilcd_xtgt_t;

   typedef enum logic [0:0] {
      ST_IDLE    = 1'b0,
      ST_BUSY    = 1'b1
   } ilcd_state_t;

   typedef struct packed {
      logic [1:0] len;
      logic [3:0] cyc;
      logic       cond;
      ilcd_kind_t kind;
   } ilcd_dec_t;

   // instruction presented for classification
   typedef struct packed {
      logic [7:0]  opcode;
      logic [7:0]  byte1;      // second instruction byte
      logic [7:0]  byte2;      // third instruction byte
      logic [15:0] pc;         // address of the opcode byte
      logic [7:0]  acc;
      logic [15:0] data_pointer_16;       // data_pointer_16
      logic [7:0]  idx_reg;    // index_register_indirect value
      logic [7:0]  xpage;      // high address byte for 8-bit forms
      logic [7:0]  ram_byte;   // indirect RAM byte for nibble exchange
      logic        cond_true;  // branch condition evaluated true
      logic        bit_set;    // tested direct bit is set
      logic        flash_sel;  // program-store access selected
   } ilcd_req_t;

   // classification result
   typedef struct packed {
      logic [1:0]  len;
      logic [3:0]  cycles;
      logic        taken;
      logic        target_ok;
      logic [15:0] target;
      logic [15:0] next_pc;
      ilcd_xtgt_t  xtarget;
      logic [15:0] xaddr;
      logic        clear_bit;
      logic        nib_ok;
      logic [7:0]  nib_acc;
      logic [7:0]  nib_ram;
   } ilcd_res_t;
endpackage

//--- test/ilcd_data_mem.sv
// partner: indirect data memory supplying the nibble exchange byte
`timescale 1ns/1ps
`default_nettype none
module ilcd_data_mem
(
   input  wire logic [7:0] addr,
   output logic      [7:0] data
);
   // inverted address, so a stuck address line shows in the data
   always_comb data = ~addr;
endmodule // ilcd_data_mem
`default_nettype wire

//--- test/ilcd_decoder_checker.sv
// checker: port-level timing and decode properties of the decoder
`timescale 1ns/1ps
`default_nettype none
module ilcd_decoder_checker
(
   input wire logic                ref_clk,
   input wire logic                sys_rst,
   input wire logic                in_valid,
   input wire logic                in_ready,
   input wire ilcd_pkg::ilcd_req_t in_req,
   input wire logic                out_valid,
   input wire ilcd_pkg::ilcd_res_t out_res
);
   import ilcd_pkg::*;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   logic [3:0] cnt_reg;
   logic [3:0] cnt_next;
   logic       take;
   assign take = in_valid && in_ready;
   // cycles since accept; 4 bits is enough, nothing runs past 8
   always_comb
   begin
      cnt_next = cnt_reg;
      if (take)
         cnt_next = 4'h1;
      else if (!in_ready)
         cnt_next = cnt_reg + 4'h1;
   end
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
         cnt_reg <= 4'h0;
      else
         cnt_reg <= cnt_next;
   end
   sequence take_s(logic [7:0] op);
      in_valid && in_ready && in_req.opcode == op;
   endsequence
   ////////////////////////////////////////////////////////////////////////
   busy_after_take_a: assert property (take |=> !in_ready)
      else $error("ready stayed high after accept");
   done_on_count_a: assert property (
      out_valid |-> cnt_reg == out_res.cycles && !in_ready)
      else $error("done pulse off the cycle count");
   ready_after_done_a: assert property (out_valid |=> in_ready)
      else $error("ready not back after done");
   hold_while_busy_a: assert property (
      !in_ready && !$past(in_ready) |-> $stable(out_res))
      else $error("result moved while busy");
   add_register_a: assert property (
      take && in_req.opcode[7:3] == 5'h05 |=>
      out_res.len == LEN_ONE && out_res.cycles == CYC_ONE)
      else $error("register add timing wrong");
   carry_taken_a: assert property (
      take_s(8'h40) ##0 in_req.cond_true |=>
      out_res.cycles == CYC_THREE && out_res.taken)
      else $error("taken carry jump timing wrong");
   divide_eight_a: assert property (
      take_s(8'h84) |=> out_res.cycles == CYC_EIGHT ##7 out_valid)
      else $error("divide not done in eight cycles");
   short_target_a: assert property (
      take_s(8'h80) |=> out_res.target_ok && out_res.target ==
      $past(in_req.pc) + 16'h2 +
      {{8{$past(in_req.byte1[7])}}, $past(in_req.byte1)})
      else $error("short jump target wrong");
   bit_clear_a: assert property (
      take_s(8'h10) ##0 in_req.bit_set |=> out_res.clear_bit)
      else $error("bit clear not flagged");
   flash_route_a: assert property (
      take_s(8'hE0) ##0 in_req.flash_sel |=> out_res.xtarget == XT_FLASH)
      else $error("flash access not routed");
   nibble_swap_a: assert property (
      take_s(8'hD6) |=> out_res.nib_acc ==
      {$past(in_req.acc[7:4]), $past(in_req.ram_byte[3:0])})
      else $error("low nibble exchange wrong");
endmodule // ilcd_decoder_checker
bind ilcd_decoder ilcd_decoder_checker chk (.ref_clk(ref_clk),
   .sys_rst(sys_rst), .in_valid(in_valid), .in_ready(in_ready),
   .in_req(in_req), .out_valid(out_valid), .out_res(out_res));
`default_nettype wire

//--- test/instruction_length_cycle_decoder_test.sv
// testbench: opcode table sweep plus branch, route and reset cases
`timescale 1ns/1ps
`default_nettype none
module instruction_length_cycle_decoder_test;
   import ilcd_pkg::*;
   logic      ref_clk = 1'b0;
   logic      sys_rst;
   logic      in_valid = 1'b0;
   logic      in_ready;
   logic      out_valid;
   ilcd_req_t req = '0;
   ilcd_req_t req_in;
   ilcd_res_t out_res;
   logic [7:0] mem_q;
   ilcd_req_t r;
   int        err_total = 0;
   int        n_checks = 0;
   int        n;
   // op, cond, len, cycles
   logic [19:0] rows [$] = '{
      20'h28_0_1_1, 20'h38_0_1_1, 20'h98_0_1_1,
      20'h25_0_2_2, 20'h24_0_2_2, 20'h26_0_1_2, 20'h96_0_1_2,
      20'h53_0_3_3, 20'h43_0_3_3, 20'h63_0_3_3, 20'h52_0_2_2,
      20'hE4_0_1_1, 20'hF4_0_1_1, 20'h23_0_1_1, 20'h33_0_1_1,
      20'h03_0_1_1, 20'h13_0_1_1, 20'hC4_0_1_1, 20'hD4_0_1_1,
      20'h85_0_3_3, 20'h90_0_3_3, 20'h93_0_1_3, 20'h83_0_1_3, // 10
      20'hE2_0_1_3, 20'hF2_0_1_3, 20'hE0_0_1_3, 20'hF0_0_1_3,
      20'hF6_0_1_2, 20'hA6_0_2_2, 20'h76_0_2_2, 20'hC0_0_2_2,
      20'hD0_0_2_2, 20'hC8_0_1_1, 20'hC5_0_2_2, 20'hD6_0_1_2, // 15
      20'hC2_0_2_2, 20'hD2_0_2_2, 20'hB2_0_2_2, 20'h82_0_2_2,
      20'hB0_0_2_2, 20'h72_0_2_2, 20'hA0_0_2_2, 20'hA2_0_2_2,
      20'h92_0_2_2, 20'h40_0_2_2, 20'h40_1_2_3, 20'h50_1_2_3,
      20'h20_0_3_3, 20'h20_1_3_4, 20'h30_1_3_4, 20'h10_1_3_4,
      20'h80_0_2_3, 20'h73_0_1_3, 20'h60_0_2_2, 20'h60_1_2_3, // 21
      20'hA4_0_1_4, 20'h84_0_1_8, 20'h11_0_2_3, 20'h01_0_2_3,
      20'h12_0_3_4, 20'h02_0_3_4, 20'h22_0_1_5, 20'h32_0_1_5,
      20'h04_0_1_1, 20'h08_0_1_1, 20'h05_0_2_2, 20'h06_0_1_2,
      20'hA3_0_1_1, 20'h14_0_1_1, 20'h00_0_1_1, 20'hA5_0_1_1};
   // the nibble exchange byte comes from the memory model
   always_comb
   begin
      req_in = req;
      req_in.ram_byte = mem_q;
   end
   ilcd_data_mem mem (.addr(req.idx_reg), .data(mem_q));
   ilcd_decoder dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .in_valid(in_valid), .in_ready(in_ready), .in_req(req_in),
      .out_valid(out_valid), .out_res(out_res));
   initial
   begin
      forever #2 ref_clk = ~ref_clk;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic start(input ilcd_req_t q);
      @(posedge ref_clk);
      req <= q;
      in_valid <= 1'b1;
      @(posedge ref_clk);
   endtask
   // one transfer; n ends as the cycle that carried the done pulse
   task automatic run(input ilcd_req_t q);
      start(q);
      in_valid <= 1'b0;
      n = 0;
      do
      begin
         @(negedge ref_clk);
         n++;
      end
      while (out_valid !== 1'b1 && n < 20);
   endtask
   task automatic mx(input logic [7:0] op, input logic [15:0] dp,
                     input logic [15:0] ix, input logic fl,
                     input ilcd_xtgt_t tg);
      r = '0;
      r.opcode = op;
      r.data_pointer_16 = dp;
      {r.xpage, r.idx_reg} = ix;
      r.flash_sel = fl;
      run(r);
      chk(16'(out_res.xtarget), 16'(tg));
      chk(out_res.xaddr, op[1] ? ix : dp);
   endtask
   task automatic rst_chk;
      chk(16'(in_ready), 16'h1);
      chk(16'(out_valid), 16'h0);
      chk(16'(out_res !== '0), 16'h0);
   endtask
   task automatic close_out;
      if (err_total == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // watchdog sized well past the whole sequence
   initial
   begin
      #80000;
      err_total++;
      close_out;
   end
   initial
   begin
      // x to 1 is a rising edge, so the async reset branch really runs
      sys_rst <= 1'b1;
      repeat (10) @(posedge ref_clk);
      rst_chk;
      sys_rst <= 1'b0;
      foreach (rows[i])
      begin
         r = '0;
         {r.opcode, r.cond_true} = {rows[i][19:12], rows[i][8]};
         run(r);
         chk(16'(out_res.len), 16'(rows[i][5:4]));
         chk(16'(out_res.cycles), 16'(rows[i][3:0]));
         chk(16'(n), 16'(rows[i][3:0]));
      end
      // backward offsets: sign must extend from the next opcode
      r = '0;
      {r.opcode, r.pc, r.byte1} = {8'h80, 16'h1000, 8'hFE};
      run(r);
      chk(out_res.target, 16'h1000);
      chk(16'(out_res.target_ok), 16'h1);
      {r.opcode, r.pc, r.byte1, r.cond_true} = {8'h40, 16'h0100, 8'h80, 1'b1};
      run(r);
      chk(out_res.target, 16'h0082);
      chk(out_res.next_pc, 16'h0102);
      {r.opcode, r.cond_true, r.bit_set} = {8'h30, 1'b0, 1'b0};
      run(r);
      chk(16'({out_res.taken, out_res.target_ok}), 16'h0);
      {r.opcode, r.cond_true, r.bit_set} = {8'h10, 1'b1, 1'b1};
      run(r);
      chk(16'(out_res.clear_bit), 16'h1);
      r.opcode = 8'h20;
      run(r);
      chk(16'(out_res.clear_bit), 16'h0);
      mx(8'hE0, 16'h0800, 16'h0000, 1'b0, XT_ONCHIP);
      mx(8'hF0, 16'h2000, 16'h0000, 1'b0, XT_OFFCHIP);
      mx(8'hE2, 16'h0000, 16'h1234, 1'b0, XT_OFFCHIP);
      mx(8'hF2, 16'h0000, 16'h0034, 1'b1, XT_FLASH);
      mx(8'hE0, 16'h0100, 16'h0000, 1'b1, XT_FLASH);
      // absolute, long, indirect and code-read addresses
      r = '0;
      {r.opcode, r.byte1, r.byte2} = {8'h02, 8'h12, 8'h34};
      run(r);
      chk(out_res.target, 16'h1234);
      {r.opcode, r.pc, r.byte1} = {8'hE1, 16'h17FE, 8'h56};
      run(r);
      chk(out_res.target, 16'h1F56);
      {r.opcode, r.acc, r.data_pointer_16} = {8'h73, 8'h10, 16'h2000};
      run(r);
      chk(out_res.target, 16'h2010);
      r.opcode = 8'h93;
      run(r);
      chk({out_res.target[14:0], out_res.target_ok}, 16'h4020);
      r = '0;
      {r.opcode, r.acc, r.idx_reg} = {8'hD6, 8'hAB, 8'h32};
      run(r);
      chk({out_res.nib_acc, out_res.nib_ram}, 16'hADCB);
      chk(16'(out_res.nib_ok), 16'h1);
      // a request offered while busy is dropped, not queued
      r = '0;
      r.opcode = 8'h84;
      start(r);
      req.opcode <= 8'h00;
      repeat (4) @(posedge ref_clk);
      in_valid <= 1'b0;
      n = 0;
      repeat (12)
      begin
         @(negedge ref_clk);
         if (out_valid === 1'b1)
            n++;
      end
      chk(16'(n), 16'h1);
      // reset in mid instruction returns to idle at once
      start(r);
      in_valid <= 1'b0;
      repeat (3) @(posedge ref_clk);
      sys_rst <= 1'b1;
      @(negedge ref_clk);
      rst_chk;
      @(posedge ref_clk);
      sys_rst <= 1'b0;
      r.opcode = 8'h00;
      run(r);
      chk(16'(n), 16'h1);
      close_out;
   end
endmodule // instruction_length_cycle_decoder_test
`default_nettype wire
